//--- audio_core_pkg.sv
/*
 * Shared constants and types of the audio processor extensions: local map,
 * clamp limits, interrupt source numbers, operation codes and sequencer states.
 * Assumes 24-bit byte addresses on the local bus and 16-bit bus halfwords.
 */
package audio_core_pkg;

  // Local address map
  localparam logic [23:0] CTRL_BASE = 24'hf1a000;
  localparam logic [23:0] CTRL_LAST = 24'hf1a1ff;
  localparam logic [23:0] RAM_BASE = 24'hf1b000;
  localparam logic [23:0] RAM_LAST = 24'hf1cfff;
  localparam logic [23:0] ROM_BASE = 24'hf1d000;
  localparam logic [23:0] ROM_LAST = 24'hf1dfff;
  localparam logic [23:0] TABLE_STEP = 24'h000200;
  localparam logic [23:0] OVF_ADDR = 24'hf1a120;
  localparam logic [23:0] MASK_ADDR = 24'hf1a118;
  localparam logic [23:0] CPU_INT_ADDR = 24'hf1a114;
  localparam logic [23:0] HIGH_HALF = 24'h000002;

  // Sizes
  localparam int RAM_WORDS = 4096;
  localparam int ROM_WORDS = 1024;

  // Reset values
  localparam logic [31:0] MASK_RESET = 32'h00000000;
  localparam logic [7:0] OVF_RESET = 8'h00;
  localparam logic [39:0] ACC_RESET = 40'h0000000000;

  // Clamp limits
  localparam logic [31:0] HALF_MIN = 32'hffff8000;
  localparam logic [31:0] HALF_MAX = 32'h00007fff;
  localparam logic [39:0] WORD_MIN = 40'hff80000000;
  localparam logic [39:0] WORD_MAX = 40'h007fffffff;

  // Interrupt source numbers
  localparam int IRQ_CPU = 0;
  localparam int IRQ_SSI = 1;
  localparam int IRQ_TIMER1 = 2;
  localparam int IRQ_TIMER2 = 3;
  localparam int IRQ_EXT0 = 4;
  localparam int IRQ_EXT1 = 5;
  localparam int IRQ_COUNT = 6;

  typedef enum logic [3:0] {
    OP_HALF_CLAMP = 4'h0, // signed_halfword_clamp
    OP_WORD_CLAMP = 4'h1, // signed_word_clamp / word_clamp_alias
    OP_QUICK_ADD = 4'h2,
    OP_QUICK_SUB = 4'h3,
    OP_QUICK_ADD_WRAPPED = 4'h4,
    OP_QUICK_SUB_WRAPPED = 4'h5,
    OP_MULTIPLY_NO_WRITEBACK = 4'h6,
    OP_MULTIPLY_ACCUMULATE_NO_WRITEBACK = 4'h7,
    OP_ACCUMULATOR_TRANSFER = 4'h8,
    OP_MATRIX_MULTIPLY = 4'h9,
    OP_SET_MASK = 4'ha
  } op_t;

  typedef enum logic [2:0] {
    WAVE_TRIANGLE = 3'h0,
    WAVE_SINE = 3'h1,
    WAVE_AM_SINE = 3'h2,
    WAVE_HARMONIC_SINE = 3'h3,
    WAVE_CHIRP = 3'h4,
    WAVE_NOISY_TRIANGLE = 3'h5,
    WAVE_SPIKE = 3'h6,
    WAVE_NOISE = 3'h7
  } wave_t;

  typedef enum logic [1:0] {
    FETCH_IDLE = 2'b00,
    FETCH_LOW = 2'b01,
    FETCH_HIGH = 2'b10
  } fetch_state_t;

endpackage : audio_core_pkg

//--- wave_table_rom.sv
/*
 * Wave table ROM: eight 128-entry tables of signed 16-bit samples.
 * Assumes the caller registers the combinational sample and sign-extends it.
 */
`timescale 1ns/10ps
module wave_table_rom (
  // Lookup
  input wire logic [9:0] word_index,
  output logic [15:0] sample
);

  function automatic int sine_at(input int ph);
    int p;
    int v;
    begin
      p = ph % 128;
      v = (p % 64) * (64 - (p % 64)) * 31;
      sine_at = (p >= 64) ? -v : v;
    end
  endfunction : sine_at

  function automatic int tri_at(input int p);
    begin
      tri_at = (p < 64) ? (p - 32) * 1000 : (96 - p) * 1000;
    end
  endfunction : tri_at

  function automatic int noise_at(input int p);
    int h;
    begin
      h = ((p * 37 + 11) * (p * 53 + 7) * 97) % 65536;
      noise_at = h - 32768;
    end
  endfunction : noise_at

  // Tables are synthetic approximations; contents computed once per entry
  function automatic logic [15:0] sample_of(input logic [9:0] idx);
    int p;
    int v;
    begin
      p = int'(idx[6:0]);
      v = 0;
      case (audio_core_pkg::wave_t'(idx[9:7]))
        audio_core_pkg::WAVE_TRIANGLE: v = tri_at(p);
        audio_core_pkg::WAVE_SINE: v = sine_at(p);
        audio_core_pkg::WAVE_AM_SINE: v = (sine_at(p * 8) * ((p < 64) ? p : 127 - p)) / 64;
        audio_core_pkg::WAVE_HARMONIC_SINE: v = sine_at(p) / 2 + sine_at(p * 2) / 2;
        audio_core_pkg::WAVE_CHIRP: v = sine_at((p * p) / 16);
        audio_core_pkg::WAVE_NOISY_TRIANGLE: v = tri_at(p) + noise_at(p) / 8;
        audio_core_pkg::WAVE_SPIKE: v = (p == 0) ? 32767 : 0;
        audio_core_pkg::WAVE_NOISE: v = noise_at(p);
        default: v = 0;
      endcase
      sample_of = v[15:0];
    end
  endfunction : sample_of

  logic [15:0] rom [0:audio_core_pkg::ROM_WORDS-1];

  always_comb begin
    for (int i = 0; i < audio_core_pkg::ROM_WORDS; i++) begin
      rom[i] = sample_of(i[9:0]);
    end
  end

  assign sample = rom[word_index];

endmodule : wave_table_rom

//--- audio_core_ext.sv
/*
 * Audio extensions of the processor core: local bus slave for the control
 * space, fast RAM and wave ROM; clamp, wrapped-pointer and 40-bit accumulate
 * datapath; interrupt source collection; 16-bit master fetch of 32-bit words.
 * Assumes the pipeline drives the op port one op per valid cycle and that
 * the system bus arbiter holds mem_ack low until a halfword is ready.
 */
// Functional notes
// - Decode control space, 8 KB RAM and wave ROM at their fixed ranges.
// - ROM holds eight 128-sample signed tables, sign-extended to 32 bits.
// - Tables start every 0x200 bytes in the fixed waveform order.
// - Halfword clamp limits a signed word to FFFF8000..00007FFF.
// - Word clamp limits overflow bits plus operand to FF80000000..007FFFFFFF.
// - Multiply ops use the 40-bit accumulator: plain multiply loads the product, the others add to it; overflow byte readable after transfer.
// - Halfword clamp ignores the accumulator overflow bits.
// - Six interrupt sources: CPU, serial audio, two timers, two external.
// - Any write to the control register raises the CPU interrupt.
// - Wrapped quick ops keep operand bits where mask is one.
// - Core masters the system map over a 16-bit memory interface.
`timescale 1ns/10ps
module audio_core_ext (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Local bus slave, 16-bit
  input wire logic ext_req,
  input wire logic ext_we,
  input wire logic [23:0] ext_addr,
  input wire logic [15:0] ext_wdata,
  output logic ext_ack_reg,
  output logic [15:0] ext_rdata_reg,
  // Datapath operation port
  input wire logic op_valid,
  input wire audio_core_pkg::op_t op_code,
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  output logic op_done_reg,
  output logic [31:0] op_result_reg,
  // Interrupt sources from pins
  input wire logic ssi_irq_pin,
  input wire logic timer1_irq_pin,
  input wire logic timer2_irq_pin,
  input wire logic ext0_irq_pin,
  input wire logic ext1_irq_pin,
  output logic [5:0] irq_src_reg,
  // Core 32-bit read request
  input wire logic core_rd_req,
  input wire logic [23:0] core_rd_addr,
  output logic core_rd_done_reg,
  output logic [31:0] core_rd_data_reg,
  // 16-bit system memory master
  output logic mem_req_reg,
  output logic [23:0] mem_addr_reg,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);

  // Address decode
  wire hit_ctrl = ext_addr >= audio_core_pkg::CTRL_BASE && ext_addr <= audio_core_pkg::CTRL_LAST;
  wire hit_ram = ext_addr >= audio_core_pkg::RAM_BASE && ext_addr <= audio_core_pkg::RAM_LAST;
  wire hit_rom = ext_addr >= audio_core_pkg::ROM_BASE && ext_addr <= audio_core_pkg::ROM_LAST;
  wire [23:0] half_addr = {ext_addr[23:1], 1'b0};
  wire [23:0] ram_off = ext_addr - audio_core_pkg::RAM_BASE;
  wire [23:0] rom_off = ext_addr - audio_core_pkg::ROM_BASE;
  wire is_mask_lo = half_addr == audio_core_pkg::MASK_ADDR;
  wire is_mask_hi = half_addr == audio_core_pkg::MASK_ADDR + audio_core_pkg::HIGH_HALF;
  wire is_ovf_lo = half_addr == audio_core_pkg::OVF_ADDR;
  wire is_cpu_int = half_addr == audio_core_pkg::CPU_INT_ADDR ||
                    half_addr == audio_core_pkg::CPU_INT_ADDR + audio_core_pkg::HIGH_HALF;
  wire wr = ext_req && ext_we;
  wire rd = ext_req && !ext_we;

  logic [15:0] ram [0:audio_core_pkg::RAM_WORDS-1];
  logic [31:0] mask_reg;
  logic [15:0] mask_low_reg;
  logic [39:0] acc_reg;
  logic [7:0] ovf_reg;
  wire [15:0] rom_sample;

  wave_table_rom u_rom (
    .word_index(rom_off[11:2]),
    .sample(rom_sample)
  );

  // Low ROM half is the sample, high half its sign
  wire [15:0] rom_half = rom_off[1] ? {16{rom_sample[15]}} : rom_sample;
  wire [15:0] ctrl_rd = is_mask_lo ? mask_reg[15:0] :
                        is_mask_hi ? mask_reg[31:16] :
                        is_ovf_lo ? {8'h00, ovf_reg} : 16'h0000;
  wire [15:0] rd_next = hit_ram ? ram[ram_off[12:1]] :
                        hit_rom ? rom_half :
                        hit_ctrl ? ctrl_rd : 16'h0000;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_ack_reg <= 1'b0;
      ext_rdata_reg <= 16'h0000;
    end else begin
      ext_ack_reg <= ext_req;
      ext_rdata_reg <= rd ? rd_next : 16'h0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr && hit_ram) begin
      ram[ram_off[12:1]] <= ext_wdata;
    end
  end

  // Low half is staged so a 32-bit mask changes atomically on the high write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_low_reg <= 16'h0000;
      mask_reg <= audio_core_pkg::MASK_RESET;
    end else if (op_valid && op_code == audio_core_pkg::OP_SET_MASK) begin
      mask_reg <= op_a;
    end else if (wr && is_mask_lo) begin
      mask_low_reg <= ext_wdata;
    end else if (wr && is_mask_hi) begin
      mask_reg <= {ext_wdata, mask_low_reg};
    end
  end

  // Datapath
  wire signed [31:0] product = $signed(op_a[15:0]) * $signed(op_b[15:0]);
  wire [39:0] product_ext = {{8{product[31]}}, product};
  wire [39:0] mac_sum = acc_reg + product_ext;
  wire [31:0] add_sum = op_a + op_b;
  wire [31:0] sub_diff = op_a - op_b;
  wire [31:0] add_wrapped = (op_a & mask_reg) | (add_sum & ~mask_reg);
  wire [31:0] sub_wrapped = (op_a & mask_reg) | (sub_diff & ~mask_reg);
  wire [31:0] half_clamped = $signed(op_a) < $signed(audio_core_pkg::HALF_MIN) ? audio_core_pkg::HALF_MIN :
                             $signed(op_a) > $signed(audio_core_pkg::HALF_MAX) ? audio_core_pkg::HALF_MAX :
                             op_a;
  // Valid only right after a transfer, while the overflow byte still matches
  wire [39:0] word_in = {ovf_reg, op_a};
  wire [39:0] word_sat = $signed(word_in) < $signed(audio_core_pkg::WORD_MIN) ? audio_core_pkg::WORD_MIN :
                         $signed(word_in) > $signed(audio_core_pkg::WORD_MAX) ? audio_core_pkg::WORD_MAX :
                         word_in;

  logic [31:0] result_next;
  logic [39:0] acc_next;
  always_comb begin
    result_next = op_result_reg;
    acc_next = acc_reg;
    case (op_code)
      audio_core_pkg::OP_HALF_CLAMP: result_next = half_clamped;
      audio_core_pkg::OP_WORD_CLAMP: result_next = word_sat[31:0];
      audio_core_pkg::OP_QUICK_ADD: result_next = add_sum;
      audio_core_pkg::OP_QUICK_SUB: result_next = sub_diff;
      audio_core_pkg::OP_QUICK_ADD_WRAPPED: result_next = add_wrapped;
      audio_core_pkg::OP_QUICK_SUB_WRAPPED: result_next = sub_wrapped;
      audio_core_pkg::OP_MULTIPLY_NO_WRITEBACK: acc_next = product_ext;
      audio_core_pkg::OP_MULTIPLY_ACCUMULATE_NO_WRITEBACK: acc_next = mac_sum;
      audio_core_pkg::OP_MATRIX_MULTIPLY: acc_next = mac_sum;
      audio_core_pkg::OP_ACCUMULATOR_TRANSFER: result_next = acc_reg[31:0];
      default: result_next = op_result_reg;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      op_done_reg <= 1'b0;
      op_result_reg <= 32'h00000000;
      acc_reg <= audio_core_pkg::ACC_RESET;
      ovf_reg <= audio_core_pkg::OVF_RESET;
    end else begin
      op_done_reg <= op_valid;
      if (op_valid) begin
        op_result_reg <= result_next;
        acc_reg <= acc_next;
        if (op_code == audio_core_pkg::OP_ACCUMULATOR_TRANSFER) begin
          ovf_reg <= acc_reg[39:32];
        end
      end
    end
  end

  // Interrupt sources; pins pass three flops, a change counts when the last two agree
  wire [4:0] pins = {ext1_irq_pin, ext0_irq_pin, timer2_irq_pin, timer1_irq_pin, ssi_irq_pin};
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] sync3_reg;
  logic [4:0] pin_level_reg;
  wire [4:0] agree = ~(sync2_reg ^ sync3_reg);
  wire [4:0] pin_level_next = (sync2_reg & agree) | (pin_level_reg & ~agree);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      sync3_reg <= 5'h00;
      pin_level_reg <= 5'h00;
      irq_src_reg <= 6'h00;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_level_reg <= pin_level_next;
      irq_src_reg[audio_core_pkg::IRQ_CPU] <= wr && is_cpu_int;
      irq_src_reg[audio_core_pkg::IRQ_EXT1:audio_core_pkg::IRQ_SSI] <= pin_level_reg;
    end
  end

  // Master fetch: a 32-bit read goes out as low halfword then high halfword
  audio_core_pkg::fetch_state_t fetch_reg;
  logic [15:0] low_half_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fetch_reg <= audio_core_pkg::FETCH_IDLE;
      mem_req_reg <= 1'b0;
      mem_addr_reg <= 24'h000000;
      low_half_reg <= 16'h0000;
      core_rd_done_reg <= 1'b0;
      core_rd_data_reg <= 32'h00000000;
    end else begin
      core_rd_done_reg <= 1'b0;
      case (fetch_reg)
        audio_core_pkg::FETCH_IDLE: begin
          if (core_rd_req) begin
            mem_req_reg <= 1'b1;
            mem_addr_reg <= {core_rd_addr[23:2], 2'b00};
            fetch_reg <= audio_core_pkg::FETCH_LOW;
          end
        end
        audio_core_pkg::FETCH_LOW: begin
          if (mem_ack) begin
            low_half_reg <= mem_rdata;
            mem_addr_reg <= mem_addr_reg + audio_core_pkg::HIGH_HALF;
            fetch_reg <= audio_core_pkg::FETCH_HIGH;
          end
        end
        audio_core_pkg::FETCH_HIGH: begin
          if (mem_ack) begin
            mem_req_reg <= 1'b0;
            core_rd_data_reg <= {mem_rdata, low_half_reg};
            core_rd_done_reg <= 1'b1;
            fetch_reg <= audio_core_pkg::FETCH_IDLE;
          end
        end
        default: begin
          mem_req_reg <= 1'b0;
          fetch_reg <= audio_core_pkg::FETCH_IDLE;
        end
      endcase
    end
  end

  // Checks
  property p_half_high;
    @(posedge sys_clk) disable iff (rst)
    op_valid && op_code == audio_core_pkg::OP_HALF_CLAMP && $signed(op_a) > $signed(audio_core_pkg::HALF_MAX)
    |=> op_result_reg == 32'h00007fff;
  endproperty
  a_half_high: assert property (p_half_high) else $error("halfword clamp high wrong");

  property p_half_low;
    @(posedge sys_clk) disable iff (rst)
    op_valid && op_code == audio_core_pkg::OP_HALF_CLAMP && $signed(op_a) < $signed(audio_core_pkg::HALF_MIN)
    |=> op_result_reg == 32'hffff8000;
  endproperty
  a_half_low: assert property (p_half_low) else $error("halfword clamp low wrong");

  property p_half_pass;
    @(posedge sys_clk) disable iff (rst)
    op_valid && op_code == audio_core_pkg::OP_HALF_CLAMP && $signed(op_a) >= -32768 && $signed(op_a) <= 32767
    |=> op_result_reg == $past(op_a);
  endproperty
  a_half_pass: assert property (p_half_pass) else $error("halfword clamp altered value");

  property p_word_high;
    @(posedge sys_clk) disable iff (rst)
    op_valid && op_code == audio_core_pkg::OP_WORD_CLAMP && !ovf_reg[7] && (ovf_reg != 8'h00 || op_a[31])
    |=> op_result_reg == 32'h7fffffff;
  endproperty
  a_word_high: assert property (p_word_high) else $error("word clamp high wrong");

  property p_ovf_transfer;
    @(posedge sys_clk) disable iff (rst)
    op_valid && op_code == audio_core_pkg::OP_ACCUMULATOR_TRANSFER
    |=> ovf_reg == $past(acc_reg[39:32]) && op_result_reg == $past(acc_reg[31:0]);
  endproperty
  a_ovf_transfer: assert property (p_ovf_transfer) else $error("overflow byte not captured");

  sequence s_ovf_read;
    rd && is_ovf_lo;
  endsequence
  property p_ovf_read;
    @(posedge sys_clk) disable iff (rst)
    s_ovf_read |=> ext_ack_reg && ext_rdata_reg == {8'h00, ovf_reg};
  endproperty
  a_ovf_read: assert property (p_ovf_read) else $error("overflow read wrong");

  property p_wrap_keep;
    @(posedge sys_clk) disable iff (rst)
    op_valid && (op_code == audio_core_pkg::OP_QUICK_ADD_WRAPPED || op_code == audio_core_pkg::OP_QUICK_SUB_WRAPPED)
    |=> (op_result_reg & $past(mask_reg)) == ($past(op_a) & $past(mask_reg));
  endproperty
  a_wrap_keep: assert property (p_wrap_keep) else $error("masked bits changed");

  property p_cpu_irq;
    @(posedge sys_clk) disable iff (rst)
    wr && is_cpu_int |=> irq_src_reg[0] ##1 !irq_src_reg[0] || $past(wr && is_cpu_int);
  endproperty
  a_cpu_irq: assert property (p_cpu_irq) else $error("cpu interrupt not raised");

  property p_rom_sign;
    @(posedge sys_clk) disable iff (rst)
    rd && hit_rom && rom_off[1] |=> ext_rdata_reg == 16'h0000 || ext_rdata_reg == 16'hffff;
  endproperty
  a_rom_sign: assert property (p_rom_sign) else $error("rom high half not sign");

  sequence s_low_ack;
    fetch_reg == audio_core_pkg::FETCH_LOW && mem_ack;
  endsequence
  property p_fetch_order;
    @(posedge sys_clk) disable iff (rst)
    s_low_ack |=> mem_req_reg && mem_addr_reg == $past(mem_addr_reg) + 24'h000002;
  endproperty
  a_fetch_order: assert property (p_fetch_order) else $error("high half not after low");

endmodule : audio_core_ext

//--- sys_mem_model.sv
/*
 * Behavioural 16-bit system memory answering the core's master fetch port.
 * Assumes one outstanding halfword request, held until acknowledged.
 */
`timescale 1ns/10ps
module sys_mem_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Latency select
  input wire logic slow,
  // 16-bit memory port
  input wire logic mem_req_reg,
  input wire logic [23:0] mem_addr_reg,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [3:0] wait_cnt;
  wire logic [3:0] wait_len = slow ? 4'h5 : 4'h0;

  // Data is a function of the address so a swapped half shows up
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0000;
      wait_cnt <= 4'h0;
    end else if (mem_req_reg && !mem_ack && wait_cnt == wait_len) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_addr_reg[15:0] ^ 16'h5a5a;
      wait_cnt <= 4'h0;
    end else begin
      // Outside an answer the data bus shows the inverse of its previous value each cycle
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt <= (mem_req_reg && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule : sys_mem_model

//--- audio_dsp_core_extensions_test.sv
/*
 * Self-checking bench of the audio core extensions: op table, local bus
 * accesses, interrupt sources and the 16-bit master fetch.
 * Assumes sys_mem_model answers the master port.
 */
`timescale 1ns/10ps
module audio_dsp_core_extensions_test;
  typedef struct {
    audio_core_pkg::op_t op;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] exp;
    logic chk;
  } row_t;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ext_req = 1'b0;
  logic ext_we = 1'b0;
  logic [23:0] ext_addr = 24'h000000;
  logic [15:0] ext_wdata = 16'h0000;
  logic op_valid = 1'b0;
  audio_core_pkg::op_t op_code = audio_core_pkg::OP_HALF_CLAMP;
  logic [31:0] op_a = 32'h00000000;
  logic [31:0] op_b = 32'h00000000;
  logic [4:0] pins = 5'h00;
  logic core_rd_req = 1'b0;
  logic [23:0] core_rd_addr = 24'h000000;
  logic slow = 1'b0;
  wire logic ext_ack_reg, op_done_reg, core_rd_done_reg, mem_req_reg, mem_ack;
  wire logic [15:0] ext_rdata_reg, mem_rdata;
  wire logic [31:0] op_result_reg, core_rd_data_reg;
  wire logic [5:0] irq_src_reg;
  wire logic [23:0] mem_addr_reg;
  int mismatches = 0;
  int checks_done = 0;
  row_t rows [18];
  logic [15:0] rd;
  logic [15:0] lo;
  logic seen;

  audio_core_ext DUT (.sys_clk(sys_clk), .rst(rst), .ext_req(ext_req), .ext_we(ext_we), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_ack_reg(ext_ack_reg), .ext_rdata_reg(ext_rdata_reg), .op_valid(op_valid),
    .op_code(op_code), .op_a(op_a), .op_b(op_b), .op_done_reg(op_done_reg), .op_result_reg(op_result_reg),
    .ssi_irq_pin(pins[0]), .timer1_irq_pin(pins[1]), .timer2_irq_pin(pins[2]), .ext0_irq_pin(pins[3]),
    .ext1_irq_pin(pins[4]), .irq_src_reg(irq_src_reg), .core_rd_req(core_rd_req), .core_rd_addr(core_rd_addr),
    .core_rd_done_reg(core_rd_done_reg), .core_rd_data_reg(core_rd_data_reg), .mem_req_reg(mem_req_reg),
    .mem_addr_reg(mem_addr_reg), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  sys_mem_model mem (.sys_clk(sys_clk), .rst(rst), .slow(slow), .mem_req_reg(mem_req_reg),
    .mem_addr_reg(mem_addr_reg), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16

  // One halfword access; ack and data are taken one cycle after the request
  task automatic bus(input logic we, input logic [23:0] addr, input logic [15:0] wdata);
    @(posedge sys_clk);
    ext_req <= 1'b1;
    ext_we <= we;
    ext_addr <= addr;
    ext_wdata <= wdata;
    @(posedge sys_clk);
    ext_req <= 1'b0;
    #1;
    chk16({15'h0000, ext_ack_reg}, 16'h0001);
    rd = ext_rdata_reg;
  endtask : bus

  task automatic run_op(input row_t r);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= r.op;
    op_a <= r.a;
    op_b <= r.b;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1;
    chk16({15'h0000, op_done_reg}, 16'h0001);
    if (r.chk) begin
      chk32(op_result_reg, r.exp);
    end
  endtask : run_op

  task automatic fetch(input logic [23:0] addr);
    @(posedge sys_clk);
    core_rd_req <= 1'b1;
    core_rd_addr <= addr;
    @(posedge sys_clk);
    core_rd_req <= 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 40 && !seen; i++) begin
      @(posedge sys_clk);
      #1;
      seen = (core_rd_done_reg === 1'b1);
    end
    // Low half from addr, high half from addr+2
    chk32(core_rd_data_reg, {(addr[15:0] + 16'h0002) ^ 16'h5a5a, addr[15:0] ^ 16'h5a5a});
  endtask : fetch

  initial begin
    #(25 * 20000);
    mismatches++;
    results();
  end

  initial begin
    rows[0] = '{audio_core_pkg::OP_HALF_CLAMP, 32'h00012345, 32'h0, 32'h00007fff, 1'b1};
    rows[1] = '{audio_core_pkg::OP_HALF_CLAMP, 32'hfffe0000, 32'h0, 32'hffff8000, 1'b1};
    rows[2] = '{audio_core_pkg::OP_HALF_CLAMP, 32'hffff8000, 32'h0, 32'hffff8000, 1'b1};
    rows[3] = '{audio_core_pkg::OP_HALF_CLAMP, 32'h00007fff, 32'h0, 32'h00007fff, 1'b1};
    rows[4] = '{audio_core_pkg::OP_SET_MASK, 32'hffffff00, 32'h0, 32'h0, 1'b0};
    rows[5] = '{audio_core_pkg::OP_QUICK_ADD_WRAPPED, 32'h000012fe, 32'h4, 32'h00001202, 1'b1};
    rows[6] = '{audio_core_pkg::OP_QUICK_SUB_WRAPPED, 32'h00001201, 32'h2, 32'h000012ff, 1'b1};
    rows[7] = '{audio_core_pkg::OP_QUICK_ADD, 32'h000000fe, 32'h4, 32'h00000102, 1'b1};
    rows[8] = '{audio_core_pkg::OP_QUICK_SUB, 32'h00000100, 32'h1, 32'h000000ff, 1'b1};
    rows[9] = '{audio_core_pkg::OP_MULTIPLY_NO_WRITEBACK, 32'h00008000, 32'h00008000, 32'h0, 1'b0};
    for (int i = 10; i < 13; i++) begin
      rows[i] = '{audio_core_pkg::OP_MULTIPLY_ACCUMULATE_NO_WRITEBACK, 32'h00008000, 32'h00008000, 32'h0, 1'b0};
    end
    rows[13] = '{audio_core_pkg::OP_ACCUMULATOR_TRANSFER, 32'h0, 32'h0, 32'h00000000, 1'b1};
    rows[14] = '{audio_core_pkg::OP_WORD_CLAMP, 32'h00000000, 32'h0, 32'h7fffffff, 1'b1};
    rows[15] = '{audio_core_pkg::OP_HALF_CLAMP, 32'h00000005, 32'h0, 32'h00000005, 1'b1};
    rows[16] = '{audio_core_pkg::OP_MATRIX_MULTIPLY, 32'h00000001, 32'h00000001, 32'h0, 1'b0};
    rows[17] = '{audio_core_pkg::OP_ACCUMULATOR_TRANSFER, 32'h0, 32'h0, 32'h00000001, 1'b1};
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk32({ext_ack_reg, op_done_reg, mem_req_reg, core_rd_done_reg, irq_src_reg}, 32'h0);
    bus(1'b0, audio_core_pkg::OVF_ADDR, 16'h0000);
    chk16(rd, 16'h0000);
    // Rows 0-3 clamp 4 mask 5-6 wrap 7-8 quick 9-13 and 16-17 accumulate 14-15 clamp
    // Row 14 clamps straight after the transfer of row 13, before any further accumulate
    foreach (rows[i]) begin
      run_op(rows[i]);
    end
    bus(1'b0, audio_core_pkg::OVF_ADDR, 16'h0000);
    chk16(rd, 16'h0001);
    bus(1'b1, audio_core_pkg::OVF_ADDR, 16'h00ff);
    bus(1'b0, audio_core_pkg::OVF_ADDR, 16'h0000);
    chk16(rd, 16'h0001);
    // Mask set over the bus: low half first, high half commits
    bus(1'b1, audio_core_pkg::MASK_ADDR, 16'h00ff);
    bus(1'b1, audio_core_pkg::MASK_ADDR + audio_core_pkg::HIGH_HALF, 16'hffff);
    // Mask ffff00ff keeps bits 7:0 and 31:16; bits 15:8 take the sum 0200
    run_op('{audio_core_pkg::OP_QUICK_ADD_WRAPPED, 32'h000001ff, 32'h1, 32'h000002ff, 1'b1});
    bus(1'b1, audio_core_pkg::RAM_BASE, 16'h1234);
    bus(1'b1, audio_core_pkg::RAM_LAST - 24'h000001, 16'habcd);
    bus(1'b0, audio_core_pkg::RAM_BASE, 16'h0000);
    chk16(rd, 16'h1234);
    bus(1'b0, audio_core_pkg::RAM_LAST - 24'h000001, 16'h0000);
    chk16(rd, 16'habcd);
    bus(1'b0, 24'hf1e000, 16'h0000);
    chk16(rd, 16'h0000);
    for (int t = 0; t < 8; t++) begin
      bus(1'b1, audio_core_pkg::ROM_BASE + 24'(t) * audio_core_pkg::TABLE_STEP, 16'h0000);
      bus(1'b0, audio_core_pkg::ROM_BASE + 24'(t) * audio_core_pkg::TABLE_STEP + 24'h000040, 16'h0000);
      lo = rd;
      bus(1'b0, audio_core_pkg::ROM_BASE + 24'(t) * audio_core_pkg::TABLE_STEP + 24'h000042, 16'h0000);
      chk16(rd, {16{lo[15]}});
    end
    bus(1'b1, audio_core_pkg::CPU_INT_ADDR, 16'h0000);
    seen = 1'b0;
    for (int i = 0; i < 3; i++) begin
      seen = seen | (irq_src_reg[audio_core_pkg::IRQ_CPU] === 1'b1);
      @(posedge sys_clk);
      #1;
    end
    chk16({15'h0000, seen}, 16'h0001);
    for (int p = 0; p < 5; p++) begin
      @(posedge sys_clk);
      pins <= 5'h01 << p;
      repeat (6) @(posedge sys_clk);
      #1;
      chk16({10'h000, irq_src_reg}, 16'h0002 << p);
    end
    @(posedge sys_clk);
    pins <= 5'h00;
    fetch(24'hf1b100);
    slow <= 1'b1;
    fetch(24'h123454);
    results();
  end
endmodule : audio_dsp_core_extensions_test
